// ---- rtl/ptc_pkg.sv ----
package ptc_pkg;
	// register byte offsets on the ahb-lite window
	localparam logic [7:0] OFF_COUNT = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h04;
	localparam logic [7:0] OFF_HALT = 8'h08;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
	localparam logic [7:0] OFF_PEND = 8'h14;
	// control register field positions
	localparam int CTRL_EDGE_BIT = 5;
	localparam int CTRL_SRC_BIT = 4;
	localparam int CTRL_DIV_LSB = 0;
	localparam int DIV_W = 4;
	localparam int PRESC_W = 8;
	// status bit positions
	localparam int STAT_ROLL_BIT = 0;
	localparam int STAT_PEND_BIT = 1;
	// reset values
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [5:0] CTRL_RST = 6'h00;
	localparam logic HALT_RST = 1'b0;
	// instruction cycle is half of the system clock
	localparam int ICYC_DIV = 2;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage : ptc_pkg

// ---- rtl/ptc_prescaler.sv ----
`timescale 1ns/10ps
// power-of-two prescaler; codes with top bit set divide by 256
module ptc_prescaler
	import ptc_pkg::*;
#(
	parameter int WIDTH = ptc_pkg::PRESC_W
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic src_pulse,
	input wire logic clear,
	input wire logic [ptc_pkg::DIV_W-1:0] div_sel,
	output logic tick
);
	// the divide decode below only spans eight prescaler bits
	if (WIDTH != 8)
	begin : g_width_check
		$error("prescaler width must be 8");
	end

	logic [WIDTH-1:0] presc_r;
	logic [WIDTH-1:0] mask;

	// terminal mask selects 2^n source pulses per tick
	always_comb
	begin
		if (div_sel[DIV_W-1])
			mask = '1;
		else
			mask = WIDTH'((1 << div_sel[DIV_W-2:0]) - 1);
	end

	// clear wins over counting; without a source pulse state is held
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			presc_r <= '0;
		else if (clear)
			presc_r <= '0;
		else if (src_pulse)
		begin
			if ((presc_r & mask) == mask)
				presc_r <= '0;
			else
				presc_r <= presc_r + 1'b1;
		end
	end

	// tick pulse on the last source pulse of a period
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			tick <= 1'b0;
		else
			tick <= !clear && src_pulse && ((presc_r & mask) == mask);
	end
endmodule : ptc_prescaler

// ---- rtl/ptc_timer.sv ----
`timescale 1ns/10ps
// Function
// - counter is an 8-bit register readable and writable by software
// - counter steps on prescaled tick and wraps unaided
// - prescaler source is instruction cycle or chosen edge of count input
// - 4-bit write-only divider select sets pulses per increment
// - wrap from all-ones to zero sets rollover pending flag
// - rollover_irq requested only while pending flag and enable both set
// - halt bit stops counting; clearing it resumes
// - writing divider select clears the 8-bit prescaler
// - direct counter write pulses a strobe and clears prescaler
// - counter advances exactly one per prescaled tick not landing on a halt or counter write
// - timer rollover rate is instruction rate / divide / 256
// - source select zero clocks prescaler from half system clock
// - codes 0..7 divide by 2^code, top bit set divides by 256
// - pending flag stays set until software writes zero to it
// - edge select zero counts rising edges, one counts falling
module ptc_timer
	import ptc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic external_count_input,
	output logic rollover_irq,
	output logic irq,
	output logic direct_write_strobe
);
	import ptc_pkg::*;
	// every check below runs on hclk and sleeps through reset
	default clocking cb_chk @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	logic [7:0] counter_value_r;
	logic [DIV_W-1:0] rate_divider_select_r;
	logic count_source_select_r;
	logic input_edge_select_r;
	logic count_halt_r;
	logic rollover_pending_flag_r;
	logic rollover_irq_enable_r;
	logic roll_stat_r;
	logic roll_mask_r;
	logic icyc_r;
	logic ext_s1_r;
	logic ext_s2_r;
	logic ext_s3_r;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic rd_pend_r;
	logic [7:0] rd_addr_r;
	logic prescaled_tick;
	logic src_pulse;
	logic presc_clear;
	logic ext_edge;
	logic wr_count;
	logic wr_ctrl;
	logic wr_pend;
	logic rd_stat;
	logic wrap;
	logic addr_ok;

	// bus always answers in zero wait states with okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	assign addr_ok = hsel && hready && htrans[1] && hsize == 3'b010;

	// capture the address phase for the following data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			rd_addr_r <= 8'h00;
		end
		else if (hready)
		begin
			wr_pend_r <= addr_ok && hwrite;
			rd_pend_r <= addr_ok && !hwrite;
			wr_addr_r <= haddr[7:0];
			rd_addr_r <= haddr[7:0];
		end
	end

	assign wr_count = wr_pend_r && wr_addr_r == OFF_COUNT;
	assign wr_ctrl = wr_pend_r && wr_addr_r == OFF_CTRL;
	assign wr_pend = wr_pend_r && wr_addr_r == OFF_PEND;
	assign rd_stat = rd_pend_r && rd_addr_r == OFF_IRQ_STAT;

	// read data is registered at the address phase for a flop output
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= ZERO_WORD;
		else if (addr_ok && !hwrite)
		begin
			unique case (haddr[7:0])
				OFF_COUNT: hrdata <= {24'h00_0000, counter_value_r};
				OFF_HALT: hrdata <= {31'h0000_0000, count_halt_r};
				OFF_IRQ_STAT: hrdata <= {30'h0000_0000,
					rollover_pending_flag_r, roll_stat_r};
				OFF_IRQ_MASK: hrdata <= {31'h0000_0000, roll_mask_r};
				OFF_PEND: hrdata <= {30'h0000_0000,
					rollover_irq_enable_r, rollover_pending_flag_r};
				default: hrdata <= ZERO_WORD; // control is write-only
			endcase
		end
	end

	// write-only mode and divider fields
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rate_divider_select_r <= CTRL_RST[DIV_W-1:0];
			count_source_select_r <= 1'b0;
			input_edge_select_r <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			rate_divider_select_r <= hwdata[CTRL_DIV_LSB +: DIV_W];
			count_source_select_r <= hwdata[CTRL_SRC_BIT];
			input_edge_select_r <= hwdata[CTRL_EDGE_BIT];
		end
	end

	// halt and mask controls
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			count_halt_r <= HALT_RST;
			roll_mask_r <= 1'b0;
			rollover_irq_enable_r <= 1'b0;
		end
		else if (wr_pend_r)
		begin
			if (wr_addr_r == OFF_HALT)
				count_halt_r <= hwdata[0];
			if (wr_addr_r == OFF_IRQ_MASK)
				roll_mask_r <= hwdata[STAT_ROLL_BIT];
			if (wr_pend)
				rollover_irq_enable_r <= hwdata[STAT_PEND_BIT];
		end
	end

	// instruction cycle enable at half the system clock
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			icyc_r <= 1'b0;
		else
			icyc_r <= !icyc_r;
	end

	// count input sampled once per instruction cycle; source must hold
	// each level over one instruction cycle or edges are missed
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_s3_r <= 1'b0;
		end
		else if (icyc_r)
		begin
			ext_s1_r <= external_count_input;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
		end
	end

	// edge on synchronised input, polarity by edge select
	assign ext_edge = input_edge_select_r ?
		(ext_s3_r && !ext_s2_r) : (!ext_s3_r && ext_s2_r);

	// halt freezes the prescaler by withholding source pulses
	assign src_pulse = !count_halt_r && icyc_r &&
		(count_source_select_r ? ext_edge : 1'b1);
	assign presc_clear = wr_ctrl || wr_count;

	ptc_prescaler #(
		.WIDTH(PRESC_W)
	) u_presc (
		.hclk(hclk),
		.hresetn(hresetn),
		.src_pulse(src_pulse),
		.clear(presc_clear),
		.div_sel(rate_divider_select_r),
		.tick(prescaled_tick)
	);

	// a tick landing on a halt or counter write is dropped
	assign wrap = prescaled_tick && !count_halt_r && !wr_count &&
		counter_value_r == 8'hFF;

	// counter: software write wins, otherwise one step per tick
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			counter_value_r <= COUNT_RST;
		else if (wr_count)
			counter_value_r <= hwdata[7:0];
		else if (prescaled_tick && !count_halt_r)
			counter_value_r <= counter_value_r + 8'h01;
	end

	// write strobe pulse for the counter write
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			direct_write_strobe <= 1'b0;
		else
			direct_write_strobe <= wr_count;
	end

	// pending flag: hardware set beats software zero-write
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rollover_pending_flag_r <= 1'b0;
		else if (wrap)
			rollover_pending_flag_r <= 1'b1;
		else if (wr_pend && !hwdata[STAT_PEND_BIT - 1])
			rollover_pending_flag_r <= 1'b0;
	end

	// sticky status cleared by reading; new event wins
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			roll_stat_r <= 1'b0;
		else if (wrap)
			roll_stat_r <= 1'b1;
		else if (rd_stat && hrdata[STAT_ROLL_BIT])
			roll_stat_r <= 1'b0; // only an event the read returned is cleared
	end

	// interrupt outputs registered
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rollover_irq <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			rollover_irq <= rollover_pending_flag_r &&
				rollover_irq_enable_r;
			irq <= roll_stat_r && roll_mask_r;
		end
	end

	// a tick that the counter is free to take
	sequence s_tick_run;
		prescaled_tick && !count_halt_r && !wr_count;
	endsequence

	// a tick that turns the counter over from all ones
	sequence s_tick_wrap;
		s_tick_run ##0 counter_value_r == 8'hFF;
	endsequence

	// a zero-write of the pending flag that no wrap overrides
	sequence s_flag_zero;
		wr_pend && !hwdata[STAT_PEND_BIT - 1] && !wrap;
	endsequence

	// a status read whose returned word still showed the event
	sequence s_stat_read;
		rd_stat && hrdata[STAT_ROLL_BIT] && !wrap;
	endsequence

	a_count_step: assert property (s_tick_run |=>
		counter_value_r == $past(counter_value_r) + 8'h01)
		else $error("counter did not step by one");

	a_halt_hold: assert property (count_halt_r && !wr_count
		|=> $stable(counter_value_r))
		else $error("counter moved while halted");

	a_wrap_flag: assert property (s_tick_wrap |=>
		rollover_pending_flag_r && counter_value_r == 8'h00)
		else $error("wrap did not set pending flag");

	a_irq_gate: assert property (rollover_irq |->
		$past(rollover_pending_flag_r) && $past(rollover_irq_enable_r))
		else $error("interrupt without enabled flag");

	a_flag_keep: assert property (
		rollover_pending_flag_r && !wr_pend |=> rollover_pending_flag_r)
		else $error("pending flag lost without write");

	a_strobe_wr: assert property (wr_count |=>
		direct_write_strobe && !prescaled_tick)
		else $error("counter write strobe missing");

	a_div_clear: assert property (wr_ctrl |=>
		u_presc.presc_r == 8'h00)
		else $error("prescaler not cleared on divider write");

	a_timer_rate: assert property (
		!count_source_select_r && !count_halt_r |-> src_pulse == icyc_r)
		else $error("timer source not instruction cycle");

	a_halt_presc: assert property (
		count_halt_r && !presc_clear |=> $stable(u_presc.presc_r))
		else $error("prescaler moved while halted");

	a_flag_clear: assert property (s_flag_zero |=>
		!rollover_pending_flag_r)
		else $error("pending flag not cleared by zero write");

	a_stat_set: assert property (wrap |=>
		roll_stat_r)
		else $error("rollover did not set sticky status");

	a_stat_clear: assert property (s_stat_read |=>
		!roll_stat_r)
		else $error("status read did not clear the event");

	a_stat_keep: assert property (roll_stat_r && !rd_stat |=>
		roll_stat_r)
		else $error("sticky status lost without a read");

	a_irq_mask: assert property (irq |->
		$past(roll_stat_r) && $past(roll_mask_r))
		else $error("interrupt without unmasked status");

	a_src_ext: assert property (count_source_select_r && !ext_edge
		|-> !src_pulse)
		else $error("count pulse without an input edge");

	a_tick_src: assert property (prescaled_tick |->
		$past(src_pulse))
		else $error("tick without a source pulse");
endmodule : ptc_timer

// ---- testbench/ptc_pin_model.sv ----
`timescale 1ns/10ps
// count pin source: sends n pulses, each level held four hclk cycles
module ptc_pin_model
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic go,
	input wire logic [7:0] n_req,
	output logic external_count_input,
	output logic busy
);
	logic [10:0] left_r;
	// eight cycles a pulse keeps both levels past one instruction cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			left_r <= 11'h000;
		else if (go)
			left_r <= {n_req, 3'b000};
		else if (left_r != 11'h000)
			left_r <= left_r - 11'h001;
	end
	// pin idles low between bursts
	assign external_count_input = left_r[2];
	assign busy = (left_r != 11'h000);
endmodule : ptc_pin_model

// ---- testbench/ptc_timer_bench.sv ----
`timescale 1ns/10ps
// directed bench: ahb-lite master tasks and expected values
module ptc_timer_bench;
	import ptc_pkg::*;
	logic hclk, hresetn, hsel, hwrite, go;
	logic [31:0] haddr, hwdata, hrdata, v, c1;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp, pin, busy, roll_irq, irq, strobe;
	logic [7:0] n_req;
	int n_fail, cmp_count, per;

	ptc_timer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp),
		.external_count_input(pin), .rollover_irq(roll_irq), .irq(irq),
		.direct_write_strobe(strobe));
	ptc_pin_model i_pin (.hclk(hclk), .hresetn(hresetn), .go(go),
		.n_req(n_req), .external_count_input(pin), .busy(busy));

	// free running 100 mhz clock
	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	function automatic logic [31:0] b8(input logic [7:0] x);
		return {24'h0000_00, x};
	endfunction : b8

	// one single word transfer; read data lands in v
	task automatic xfer(input logic we, input logic [7:0] a,
		input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0000_00, a};
		htrans <= 2'b10;
		hwrite <= we;
		hsize <= 3'b010;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		v = hrdata;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		xfer(1'b0, a, ZERO_WORD);
	endtask : rd

	task automatic gap(input int n);
		repeat (n) @(posedge hclk);
	endtask : gap

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic pulses(input logic [7:0] n);
		go <= 1'b1;
		n_req <= n;
		@(posedge hclk);
		go <= 1'b0;
		gap(2);
		while (busy) @(posedge hclk);
		gap(20);
	endtask : pulses

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish

	// hang guard, well past the expected run length
	initial
	begin
		repeat (40000) @(posedge hclk);
		n_fail++;
		tally_and_finish;
	end

	// main sequence
	initial
	begin
		{hsel, hwrite, go, htrans, haddr, hwdata, n_req} = '0;
		hsize = 3'b010;
		n_fail = 0;
		cmp_count = 0;
		hresetn = 1'b0;
		gap(8);
		hresetn <= 1'b1;
		rd(OFF_PEND);
		chk("pend_reset", ZERO_WORD, v);
		chk("rst_out", ZERO_WORD, {29'h0, roll_irq, irq, strobe});
		chk("resp_okay", 32'h2, {30'h0, hreadyout, hresp});
		wr(OFF_HALT, 32'h0000_0001);
		wr(OFF_COUNT, 32'h0000_005A);
		gap(1);
		chk("strobe", 32'h1, {31'h0, strobe});
		rd(OFF_COUNT);
		chk("count_rw", 32'h0000_005A, v);
		gap(100);
		rd(OFF_COUNT);
		chk("count_halt", 32'h0000_005A, v);
		rd(OFF_CTRL);
		chk("ctrl_wo", ZERO_WORD, v);
		rd(8'h20);
		chk("unmapped", ZERO_WORD, v);
		wr(OFF_HALT, ZERO_WORD);
		gap(40);
		rd(OFF_COUNT);
		chk("resume", 32'h1, {31'h0, v[7:0] != 8'h5A});
		// rate of divider codes 0 to 8 and 15, count delta over four periods
		for (int d = 0; d < 10; d++)
		begin
			wr(OFF_CTRL, (d == 9) ? 32'h0000_000F : 32'(d));
			per = 2 << ((d > 8) ? 8 : d);
			rd(OFF_COUNT);
			c1 = v;
			gap(4 * per - 2);
			rd(OFF_COUNT);
			chk("rate", b8(c1[7:0] + 8'h04), b8(v[7:0]));
		end
		// rewrite of ctrl or count must restart the 512 cycle period
		for (int i = 0; i < 2; i++)
		begin
			wr(OFF_CTRL, 32'h0000_0008);
			wr(OFF_COUNT, ZERO_WORD);
			gap(400);
			if (i == 0)
				wr(OFF_CTRL, 32'h0000_0008);
			else
				wr(OFF_COUNT, ZERO_WORD);
			gap(400);
			rd(OFF_COUNT);
			chk("presc_clear", ZERO_WORD, b8(v[7:0]));
			gap(200);
			rd(OFF_COUNT);
			chk("first_tick", 32'h1, b8(v[7:0]));
		end
		// wrap from all ones, flag, enable and mask
		wr(OFF_HALT, 32'h0000_0001);
		wr(OFF_CTRL, ZERO_WORD);
		wr(OFF_COUNT, 32'h0000_00FE);
		wr(OFF_PEND, ZERO_WORD);
		rd(OFF_IRQ_STAT);
		wr(OFF_HALT, ZERO_WORD);
		gap(30);
		wr(OFF_HALT, 32'h0000_0001);
		rd(OFF_PEND);
		chk("pend_set", 32'h1, v);
		chk("roll_irq_off", ZERO_WORD, {31'h0, roll_irq});
		chk("irq_masked", ZERO_WORD, {31'h0, irq});
		wr(OFF_IRQ_MASK, 32'h0000_0001);
		gap(2);
		chk("irq_on", 32'h1, {31'h0, irq});
		rd(OFF_IRQ_STAT);
		chk("stat", 32'h3, v);
		gap(2);
		chk("irq_clr", ZERO_WORD, {31'h0, irq});
		wr(OFF_PEND, 32'h0000_0003);
		gap(2);
		chk("roll_irq_on", 32'h1, {31'h0, roll_irq});
		wr(OFF_PEND, 32'h0000_0002);
		gap(2);
		chk("roll_irq_clr", ZERO_WORD, {31'h0, roll_irq});
		rd(OFF_PEND);
		chk("pend_clr", 32'h2, v);
		// counter mode on rising, then falling edges of the pin
		wr(OFF_CTRL, 32'h0000_0010);
		wr(OFF_COUNT, ZERO_WORD);
		wr(OFF_HALT, ZERO_WORD);
		pulses(8'h05);
		rd(OFF_COUNT);
		chk("ext_rise", 32'h5, b8(v[7:0]));
		wr(OFF_CTRL, 32'h0000_0030);
		pulses(8'h03);
		rd(OFF_COUNT);
		chk("ext_fall", 32'h8, b8(v[7:0]));
		tally_and_finish;
	end
endmodule : ptc_timer_bench
